/* hw/ean_params.svh */
/*
 * Constants of the auto-negotiation control block: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 100 MHz system clock and a 5-bit management register address.
 */
// Summary of operation
// R1 - Negotiation strap low: force speed from speed strap, duplex from duplex strap.
// R2 - Negotiation strap high: straps pick advertised set 10 HD/FD, 100 HD/FD, both HD, all.
// R3 - Strap levels load advertisement bits 8 to 5 at reset.
// R4 - Writes to basic control at 00h override strapped behaviour any time after reset; writes during strap capture (st_strap) are dropped.
// R5 - Speed and duplex straps never change basic control contents.
// R6 - While negotiating, advertisement register 04h is sent as link pulse bursts.
// R7 - Summary status speed and duplex bits valid only when forced or complete.
// R8 - Resolve common abilities: 100 full, 100 half, 10 full, 10 half.
// R9 - Summary status reports completion, resolved duplex and resolved speed.
// R10 - Forced mode uses control speed and duplex bits; ignored while negotiation enabled.
// R11 - Basic status ability bits fixed set except T4; completion, fault, link, preamble shown.
// R12 - All abilities advertised by default; software may clear advertisement bits.
// R13 - Each received base or next page word is stored in partner abilities 05h.
// R14 - Parallel detect completion loads partner abilities 0081h or 0021h.
// R15 - Expansion status shows fault, partner next page, local next page, page, partner able.
// R16 - Parallel detect watches both receivers and configures to the one with link.
// R17 - Parallel detect completion leaves partner-negotiation-able at zero.
// R18 - Anything but exactly one good link during parallel detect sets fault; code sets it only when both links are up.
// R19 - Writing one to control bit 9 restarts negotiation.
// R20 - Loss of link after negotiation restarts the negotiation.
// R21 - Renegotiation holds transmit and pulses for break-link time, then sends bursts.
// R22 - After forced straps, software clears then sets control bit 12 to negotiate.
`ifndef EAN_PARAMS_SVH
`define EAN_PARAMS_SVH

`define EAN_REG_CTRL       5'h00
`define EAN_REG_STAT       5'h01
`define EAN_REG_ADV        5'h04
`define EAN_REG_LP         5'h05
`define EAN_REG_EXP        5'h06
`define EAN_REG_SUM        5'h10

`define EAN_CTRL_RESET     15
`define EAN_CTRL_SPEED     13
`define EAN_CTRL_NEG_EN    12
`define EAN_CTRL_RESTART   9
`define EAN_CTRL_DUPLEX    8

`define EAN_STAT_FIXED     16'h7849
`define EAN_STAT_AN_DONE   5
`define EAN_STAT_RFAULT    4
`define EAN_STAT_LINK      2
`define EAN_LP_RFAULT      13
`define EAN_LP_NEXT_PAGE   15

`define EAN_ADV_SELECTOR   16'h0001
`define EAN_ADV_LO         5
`define EAN_ADV_HI         8
`define EAN_ADV_STRAP_00   4'h3
`define EAN_ADV_STRAP_01   4'hC
`define EAN_ADV_STRAP_10   4'h5
`define EAN_ADV_STRAP_11   4'hF
`define EAN_LP_PD_100      16'h0081
`define EAN_LP_PD_10       16'h0021

`define EAN_EXP_PD_FAULT   4
`define EAN_EXP_LP_NP      3
`define EAN_EXP_LOC_NP     2
`define EAN_EXP_PAGE       1
`define EAN_EXP_LP_AN      0

`define EAN_SUM_AN_DONE    4
`define EAN_SUM_DUPLEX     2
`define EAN_SUM_SPEED10    1
`define EAN_SUM_LINK       0

`define EAN_STRAP_SETTLE   2'h3
`define EAN_BREAK_LINK_MS  1500
`define EAN_CLK_PER_MS     100000
`define EAN_TIMER_W        28

`endif

/* hw/ean_pkg.sv */
/*
 * Types of the auto-negotiation control block: management request carrier,
 * negotiation states and the block's whole register state.
 * Assumes ean_params.svh for field widths.
 */
`include "ean_params.svh"

package ean_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } ean_mgmt_req_s;

    typedef enum logic [2:0] {
        st_strap,
        st_forced,
        st_break,
        st_detect,
        st_good
    } ean_state_e;

    typedef struct packed {
        logic [2:0]              strap_meta;
        logic [2:0]              strap_sync;
        logic [1:0]              settle;
        ean_state_e              fsm;
        logic                    ctrl_speed;
        logic                    ctrl_neg_en;
        logic                    ctrl_duplex;
        logic                    ctrl_written;
        logic [15:0]             adv;
        logic [15:0]             lp;
        logic                    pd_fault;
        logic                    page_rcvd;
        logic                    lp_an_able;
        logic                    an_done;
        logic                    res_100;
        logic                    res_full;
        logic                    link_seen;
        logic [`EAN_TIMER_W-1:0] timer;
        logic [15:0]             rdata;
    } ean_regs_s;

endpackage : ean_pkg

/* hw/ean_autoneg.sv */
/*
 * Auto-negotiation control of a 10/100 twisted-pair physical layer device:
 * strap capture, management registers, ability exchange control, priority
 * resolution, parallel detection and break-link renegotiation.
 * Assumes the pulse encoder/decoder and the 10/100 link monitors run on
 * clk_sys_i; only the three strap pins arrive from outside the clock domain.
 */
`timescale 1ns/1ps
`include "ean_params.svh"

module ean_autoneg #(
    parameter int unsigned BREAK_LINK_CYC = `EAN_BREAK_LINK_MS * `EAN_CLK_PER_MS
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  negotiation_strap_i,
    input  wire logic                  speed_strap_i,
    input  wire logic                  duplex_strap_i,
    input  wire ean_pkg::ean_mgmt_req_s mgmt_req_i,
    output logic [15:0]                mgmt_rdata_o,
    input  wire logic                  page_rx_i,
    input  wire logic [15:0]           page_word_i,
    input  wire logic                  link_10_i,
    input  wire logic                  link_100_i,
    output logic                       flp_enable_o,
    output logic                       tx_hold_o,
    output logic [15:0]                adv_word_o,
    output logic                       speed_100_o,
    output logic                       full_duplex_o,
    output logic                       link_up_o,
    output logic                       an_complete_o
);
    import ean_pkg::*;

    localparam logic [`EAN_TIMER_W-1:0] TIMER_LOAD = `EAN_TIMER_W'(BREAK_LINK_CYC - 1);

    ean_regs_s r;
    ean_regs_s next_r;

    logic [3:0]  common;
    logic [2:0]  pick;
    logic        link_ok;
    logic        mode_valid;
    logic        wr_ctrl;
    logic        wr_adv;
    logic        rd_any;
    logic [15:0] stat_word;
    logic [15:0] exp_word;
    logic [15:0] sum_word;

    // Returns {found, speed_100, full}; bit order 100FD, 100HD, 10FD, 10HD
    function automatic logic [2:0] resolve(input logic [3:0] c);
        logic [2:0] res;
        res = 3'h0;
        if (c[3]) begin
            res = 3'h7;
        end else if (c[2]) begin
            res = 3'h6;
        end else if (c[1]) begin
            res = 3'h5;
        end else if (c[0]) begin
            res = 3'h4;
        end
        return res;
    endfunction : resolve

    function automatic logic [3:0] strap_adv(input logic [1:0] s);
        logic [3:0] a;
        case (s)
            2'h0:    a = `EAN_ADV_STRAP_00;
            2'h1:    a = `EAN_ADV_STRAP_01;
            2'h2:    a = `EAN_ADV_STRAP_10;
            default: a = `EAN_ADV_STRAP_11;
        endcase
        return a;
    endfunction : strap_adv

    always_comb begin
        common     = r.adv[`EAN_ADV_HI:`EAN_ADV_LO] & page_word_i[`EAN_ADV_HI:`EAN_ADV_LO]; // R8
        pick       = resolve(common); // R8
        link_ok    = r.res_100 ? link_100_i : link_10_i;
        mode_valid = (r.fsm == st_forced) || r.an_done; // R7
        wr_ctrl    = mgmt_req_i.wr && (mgmt_req_i.addr == `EAN_REG_CTRL) && (r.fsm != st_strap);
        wr_adv     = mgmt_req_i.wr && (mgmt_req_i.addr == `EAN_REG_ADV) && (r.fsm != st_strap);
        rd_any     = mgmt_req_i.rd;

        stat_word = `EAN_STAT_FIXED; // R11
        stat_word[`EAN_STAT_AN_DONE] = r.an_done; // R11
        stat_word[`EAN_STAT_RFAULT]  = r.lp[`EAN_LP_RFAULT]; // R11
        stat_word[`EAN_STAT_LINK]    = r.link_seen; // R11

        exp_word = 16'h0000;
        exp_word[`EAN_EXP_PD_FAULT] = r.pd_fault; // R15
        exp_word[`EAN_EXP_LP_NP]    = r.lp_an_able & r.lp[`EAN_LP_NEXT_PAGE]; // R15
        exp_word[`EAN_EXP_LOC_NP]   = 1'b0; // R15
        exp_word[`EAN_EXP_PAGE]     = r.page_rcvd; // R15
        exp_word[`EAN_EXP_LP_AN]    = r.lp_an_able; // R15

        sum_word = 16'h0000;
        sum_word[`EAN_SUM_AN_DONE] = r.an_done; // R9
        sum_word[`EAN_SUM_DUPLEX]  = mode_valid & r.res_full; // R7 R9
        sum_word[`EAN_SUM_SPEED10] = mode_valid & ~r.res_100; // R7 R9
        sum_word[`EAN_SUM_LINK]    = r.link_seen;

        next_r            = r;
        next_r.strap_meta = {negotiation_strap_i, speed_strap_i, duplex_strap_i};
        next_r.strap_sync = r.strap_meta;

        // Read data, with read-to-clear of the expansion event flags
        if (rd_any) begin
            case (mgmt_req_i.addr)
                `EAN_REG_CTRL: begin
                    next_r.rdata = 16'h0000;
                    next_r.rdata[`EAN_CTRL_SPEED]  = r.ctrl_speed; // R5
                    next_r.rdata[`EAN_CTRL_NEG_EN] = r.ctrl_neg_en;
                    next_r.rdata[`EAN_CTRL_DUPLEX] = r.ctrl_duplex; // R5
                end
                `EAN_REG_STAT: next_r.rdata = stat_word;
                `EAN_REG_ADV:  next_r.rdata = r.adv;
                `EAN_REG_LP:   next_r.rdata = r.lp;
                `EAN_REG_EXP: begin
                    next_r.rdata     = exp_word;
                    next_r.pd_fault  = 1'b0;
                    next_r.page_rcvd = 1'b0;
                end
                `EAN_REG_SUM:  next_r.rdata = sum_word;
                default:       next_r.rdata = 16'h0000;
            endcase
        end

        if (wr_adv) begin
            next_r.adv = mgmt_req_i.wdata; // R12
        end

        if (wr_ctrl) begin
            // Straps never touch the speed and duplex bits, only software does
            next_r.ctrl_speed   = mgmt_req_i.wdata[`EAN_CTRL_SPEED]; // R4 R5
            next_r.ctrl_duplex  = mgmt_req_i.wdata[`EAN_CTRL_DUPLEX]; // R4 R5
            next_r.ctrl_neg_en  = mgmt_req_i.wdata[`EAN_CTRL_NEG_EN]; // R4
            next_r.ctrl_written = 1'b1; // R4
        end

        case (r.fsm)
            st_strap: begin
                // Wait for the synchronised strap levels to settle before capture
                next_r.settle = r.settle + 2'h1;
                if (r.settle == `EAN_STRAP_SETTLE) begin
                    next_r.settle     = 2'h0;
                    next_r.ctrl_neg_en = r.strap_sync[2];
                    next_r.adv        = `EAN_ADV_SELECTOR;
                    next_r.adv[`EAN_ADV_HI:`EAN_ADV_LO] = strap_adv(r.strap_sync[1:0]); // R2 R3 R12
                    if (r.strap_sync[2]) begin
                        next_r.fsm = st_detect;
                    end else begin
                        next_r.fsm      = st_forced;
                        next_r.res_100  = r.strap_sync[1]; // R1
                        next_r.res_full = r.strap_sync[0]; // R1
                    end
                end
            end

            st_forced: begin
                next_r.an_done   = 1'b0;
                next_r.link_seen = link_ok;
                if (r.ctrl_written) begin
                    next_r.res_100  = r.ctrl_speed; // R10
                    next_r.res_full = r.ctrl_duplex; // R10
                end
                // Only a 0 to 1 edge of the enable starts negotiation here
                if (wr_ctrl && mgmt_req_i.wdata[`EAN_CTRL_NEG_EN]) begin // R22
                    next_r.fsm   = st_break; // R22
                    next_r.timer = TIMER_LOAD; // R21
                end
            end

            st_break: begin
                // Transmit and pulses held off so the partner drops link
                next_r.an_done    = 1'b0;
                next_r.link_seen  = 1'b0;
                next_r.lp_an_able = 1'b0;
                next_r.timer      = r.timer - `EAN_TIMER_W'(1); // R21
                if (r.timer == '0) begin
                    next_r.fsm = st_detect; // R21
                end
            end

            st_detect: begin
                if (page_rx_i) begin
                    next_r.lp         = page_word_i; // R13
                    next_r.page_rcvd  = 1'b1; // R15
                    next_r.lp_an_able = 1'b1; // R15
                    if (pick[2]) begin
                        next_r.res_100 = pick[1]; // R8
                        next_r.res_full = pick[0]; // R8
                        next_r.an_done = 1'b1; // R9
                        next_r.fsm     = st_good;
                    end
                end else if (link_10_i ^ link_100_i) begin // R16
                    // Parallel detection cannot see duplex, so half is taken
                    next_r.lp         = link_100_i ? `EAN_LP_PD_100 : `EAN_LP_PD_10; // R14
                    next_r.res_100    = link_100_i; // R16
                    next_r.res_full   = 1'b0;
                    next_r.lp_an_able = 1'b0; // R17
                    next_r.an_done    = 1'b1;
                    next_r.fsm        = st_good;
                end else if (link_10_i && link_100_i) begin
                    next_r.pd_fault = 1'b1; // R18
                end
            end

            st_good: begin
                if (page_rx_i) begin
                    next_r.lp        = page_word_i; // R13
                    next_r.page_rcvd = 1'b1;
                end
                if (link_ok) begin
                    next_r.link_seen = 1'b1;
                end else if (r.link_seen) begin
                    next_r.fsm   = st_break; // R20
                    next_r.timer = TIMER_LOAD; // R21
                end
            end

            default: begin
                next_r.fsm = st_strap;
            end
        endcase

        // Control writes take precedence over the sequence above
        if (wr_ctrl) begin
            if (!mgmt_req_i.wdata[`EAN_CTRL_NEG_EN]) begin
                // Forced mode follows the written bits at once
                next_r.fsm      = st_forced; // R10
                next_r.an_done  = 1'b0;
                next_r.res_100  = mgmt_req_i.wdata[`EAN_CTRL_SPEED]; // R10
                next_r.res_full = mgmt_req_i.wdata[`EAN_CTRL_DUPLEX]; // R10
            end else if (mgmt_req_i.wdata[`EAN_CTRL_RESTART] && r.ctrl_neg_en) begin
                next_r.fsm   = st_break; // R19 R21
                next_r.timer = TIMER_LOAD; // R21
            end
            if (mgmt_req_i.wdata[`EAN_CTRL_RESET]) begin
                // Soft reset re-captures the straps like a hardware reset
                next_r.fsm          = st_strap;
                next_r.settle       = 2'h0;
                next_r.ctrl_speed   = 1'b0;
                next_r.ctrl_duplex  = 1'b0;
                next_r.ctrl_written = 1'b0;
                next_r.lp           = 16'h0000;
                next_r.pd_fault     = 1'b0;
                next_r.page_rcvd    = 1'b0;
                next_r.lp_an_able   = 1'b0;
                next_r.an_done      = 1'b0;
                next_r.link_seen    = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r.strap_meta   <= 3'h0;
            r.strap_sync   <= 3'h0;
            r.settle       <= 2'h0;
            r.fsm          <= st_strap;
            r.ctrl_speed   <= 1'b0;
            r.ctrl_neg_en  <= 1'b0;
            r.ctrl_duplex  <= 1'b0;
            r.ctrl_written <= 1'b0;
            r.adv          <= `EAN_ADV_SELECTOR;
            r.lp           <= 16'h0000;
            r.pd_fault     <= 1'b0;
            r.page_rcvd    <= 1'b0;
            r.lp_an_able   <= 1'b0;
            r.an_done      <= 1'b0;
            r.res_100      <= 1'b0;
            r.res_full     <= 1'b0;
            r.link_seen    <= 1'b0;
            r.timer        <= '0;
            r.rdata        <= 16'h0000;
        end else begin
            r <= next_r;
        end
    end

    assign mgmt_rdata_o  = r.rdata;
    assign flp_enable_o  = (r.fsm == st_detect); // R6
    assign tx_hold_o     = (r.fsm == st_break); // R21
    assign adv_word_o    = r.adv; // R6
    assign speed_100_o   = r.res_100;
    assign full_duplex_o = r.res_full;
    assign link_up_o     = r.link_seen;
    assign an_complete_o = r.an_done;

endmodule : ean_autoneg

/* verif/ean_autoneg_props.sv */
/* Port checker for ean_autoneg, bound to every instance.
   Assumes one clock domain and requests no earlier than edge 6 after reset release. */
`timescale 1ns/1ps
module ean_autoneg_chk
    import ean_pkg::*;
#(
    parameter int unsigned BREAK_LINK_CYC = 20
) (
    input wire logic          clk_sys_i,
    input wire logic          arst_n_i,
    input wire ean_mgmt_req_s mgmt_req_i,
    input wire logic [15:0]   mgmt_rdata_o,
    input wire logic          page_rx_i,
    input wire logic [15:0]   page_word_i,
    input wire logic          link_10_i,
    input wire logic          link_100_i,
    input wire logic          flp_enable_o,
    input wire logic          tx_hold_o,
    input wire logic [15:0]   adv_word_o,
    input wire logic          speed_100_o,
    input wire logic          full_duplex_o,
    input wire logic          an_complete_o
);
    logic [2:0]  age;
    logic [31:0] held;
    logic        ready;
    logic        wr_ctl;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            age  <= 3'h0;
            held <= 32'h0;
        end else begin
            age  <= (age == 3'h7) ? age : age + 3'h1;
            held <= tx_hold_o ? held + 32'h1 : 32'h0;
        end
    end
    // Strap phase drops writes, so checks on writes wait for it
    assign ready  = (age >= 3'h5);
    assign wr_ctl = mgmt_req_i.wr && ready && (mgmt_req_i.addr == 5'h00);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    chk_hold_quiet: assert property (tx_hold_o |-> !flp_enable_o)
        else $error("bursts sent during break");
    chk_break_len: assert property ($fell(tx_hold_o) |-> held >= BREAK_LINK_CYC && held <= BREAK_LINK_CYC + 1)
        else $error("break length wrong");
    chk_bursts_after: assert property ($fell(tx_hold_o) |-> ##[0:1] flp_enable_o)
        else $error("no bursts after break");
    chk_restart_hold: assert property (wr_ctl && mgmt_req_i.wdata[12] && mgmt_req_i.wdata[9] |=> tx_hold_o)
        else $error("restart did not break link");
    chk_forced_mode: assert property (wr_ctl && !mgmt_req_i.wdata[12] |=> !tx_hold_o && !flp_enable_o
        && speed_100_o == $past(mgmt_req_i.wdata[13]) && full_duplex_o == $past(mgmt_req_i.wdata[8]))
        else $error("forced mode not taken from control");
    chk_adv_write: assert property (mgmt_req_i.wr && ready && mgmt_req_i.addr == 5'h04
        |=> adv_word_o == $past(mgmt_req_i.wdata))
        else $error("advertisement write lost");
    chk_status_bits: assert property (mgmt_req_i.rd && mgmt_req_i.addr == 5'h01
        |=> (mgmt_rdata_o & 16'h7849) == 16'h7849 && mgmt_rdata_o[5] == $past(an_complete_o))
        else $error("status bits wrong");
    chk_ctrl_read: assert property (mgmt_req_i.rd && mgmt_req_i.addr == 5'h00
        |=> (mgmt_rdata_o & 16'h4EFF) == 16'h0000)
        else $error("control has stray bits");
    chk_pd_100: assert property (flp_enable_o && link_100_i && !link_10_i && !page_rx_i && !mgmt_req_i.wr
        |=> an_complete_o && speed_100_o && !full_duplex_o)
        else $error("parallel detect 100 failed");
    chk_an_top: assert property (flp_enable_o && page_rx_i && page_word_i[8] && adv_word_o[8] && !link_10_i
        && !link_100_i && !mgmt_req_i.wr |=> an_complete_o && speed_100_o && full_duplex_o)
        else $error("top priority not chosen");
    cover property ($rose(tx_hold_o));
    cover property ($rose(an_complete_o));
    cover property (page_rx_i && flp_enable_o);
endmodule : ean_autoneg_chk

bind ean_autoneg ean_autoneg_chk #(.BREAK_LINK_CYC(BREAK_LINK_CYC)) u_chk (.clk_sys_i, .arst_n_i, .mgmt_req_i,
    .mgmt_rdata_o, .page_rx_i, .page_word_i, .link_10_i, .link_100_i, .flp_enable_o, .tx_hold_o, .adv_word_o,
    .speed_100_o, .full_duplex_o, .an_complete_o);

/* verif/ean_partner.sv */
/* Remote link partner: base pages and receiver link levels.
   Assumes the block's clock; the bench drives it through its tasks. */
`timescale 1ns/1ps
module ean_partner (
    input  wire logic  clk_sys_i,
    input  wire logic  flp_enable_i,
    output logic        page_rx_o,
    output logic [15:0] page_word_o,
    output logic        link_10_o,
    output logic        link_100_o
);
    initial begin
        page_rx_o   = 1'b0;
        page_word_o = 16'hA5A5;
        link_10_o   = 1'b0;
        link_100_o  = 1'b0;
    end
    // Waits up to 200 cycles for bursts, then answers; gap makes a slow partner
    task automatic send_page(input logic [15:0] word, input int gap);
        int n;
        n = 0;
        while (!flp_enable_i && n < 200) begin
            @(negedge clk_sys_i);
            n++;
        end
        repeat (gap) @(negedge clk_sys_i);
        page_word_o = word;
        page_rx_o   = 1'b1;
        @(negedge clk_sys_i);
        page_rx_o   = 1'b0;
        page_word_o = ~word; // Stale word must never look valid
    endtask : send_page
    task automatic set_links(input logic l10, input logic l100);
        @(negedge clk_sys_i);
        link_10_o  = l10;
        link_100_o = l100;
    endtask : set_links
endmodule : ean_partner

/* verif/ean_autoneg_test.sv */
/* Self-checking bench for ean_autoneg with a partner model.
   Assumes a short break-link count and inputs driven on falling edges. */
`timescale 1ns/1ps
module ean_autoneg_test;
    import ean_pkg::*;
    localparam int unsigned BRK = 20;
    logic          clk_sys_i, arst_n_i, neg_s, spd_s, dup_s;
    ean_mgmt_req_s req;
    logic [15:0]   rdata, adv, rd_val, page_word;
    logic          page_rx, link_10, link_100, flp, hold, spd100, fdx, lnk, done;
    int            fail_count, checked;

    ean_autoneg #(.BREAK_LINK_CYC(BRK)) dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .negotiation_strap_i(neg_s), .speed_strap_i(spd_s), .duplex_strap_i(dup_s), .mgmt_req_i(req),
        .mgmt_rdata_o(rdata), .page_rx_i(page_rx), .page_word_i(page_word), .link_10_i(link_10),
        .link_100_i(link_100), .flp_enable_o(flp), .tx_hold_o(hold), .adv_word_o(adv),
        .speed_100_o(spd100), .full_duplex_o(fdx), .link_up_o(lnk), .an_complete_o(done));
    ean_partner pe (.clk_sys_i(clk_sys_i), .flp_enable_i(flp), .page_rx_o(page_rx),
        .page_word_o(page_word), .link_10_o(link_10), .link_100_o(link_100));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        req = '{1'b1, 1'b0, a, d};
        @(negedge clk_sys_i);
        req = '0;
    endtask : wr
    task automatic chk_rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
        req = '{1'b0, 1'b1, a, 16'h0000};
        @(negedge clk_sys_i);
        req = '0;
        rd_val = rdata;
        chk(rd_val & m, e, "read");
    endtask : chk_rd
    task automatic boot(input logic n, input logic s, input logic d);
        neg_s = n;
        spd_s = s;
        dup_s = d;
        arst_n_i = 1'b0;
        repeat (20) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        repeat (7) @(negedge clk_sys_i);
    endtask : boot
    task automatic wait_burst();
        int n;
        n = 0;
        while ((hold || !flp) && n < 4 * BRK) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk({15'h0, flp}, 16'h0001, "bursts");
    endtask : wait_burst
    task automatic restart();
        wr(5'h00, 16'h1200);
        chk({15'h0, hold}, 16'h0001, "hold");
        wait_burst();
    endtask : restart

    task automatic test_straps();
        logic [3:0] ab [4];
        ab = '{4'h3, 4'hC, 4'h5, 4'hF};
        for (int i = 0; i < 8; i++) begin
            boot(i[2], i[1], i[0]);
            chk({14'h0, flp, hold}, {14'h0, i[2], 1'b0}, "strap mode");
            if (i[2]) begin
                chk(adv, {7'h00, ab[i[1:0]], 5'h01}, "adv strap");
                chk_rd(5'h01, 16'hFFFF, 16'h7849);
            end else begin
                chk({14'h0, spd100, fdx}, {14'h0, i[1], i[0]}, "forced");
            end
            chk_rd(5'h00, 16'h7FFF, {3'h0, i[2], 12'h000});
        end
        chk_rd(5'h03, 16'hFFFF, 16'h0000);
        $display("straps done");
    endtask : test_straps

    task automatic test_priority();
        logic [15:0] pw [4];
        logic [2:0]  ex [4];
        pw = '{16'h01E1, 16'h00E1, 16'h0061, 16'h0021};
        ex = '{3'h7, 3'h6, 3'h5, 3'h4};
        boot(1'b1, 1'b1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            restart();
            pe.send_page(pw[i], i);
            chk({13'h0, done, spd100, fdx}, {13'h0, ex[i]}, "resolve");
            chk_rd(5'h05, 16'hFFFF, pw[i]);
        end
        chk_rd(5'h10, 16'h0016, 16'h0012);
        chk_rd(5'h06, 16'h0007, 16'h0003);
        wr(5'h04, 16'h0041);
        chk(adv, 16'h0041, "adv write");
        restart();
        pe.send_page(16'h01E1, 0);
        chk({13'h0, done, spd100, fdx}, 16'h0005, "suppressed");
        $display("priority done");
    endtask : test_priority

    task automatic test_parallel();
        boot(1'b1, 1'b1, 1'b1);
        pe.set_links(1'b0, 1'b1);
        @(negedge clk_sys_i);
        chk({13'h0, done, spd100, fdx}, 16'h0006, "pd 100");
        chk_rd(5'h05, 16'hFFFF, 16'h0081);
        chk_rd(5'h06, 16'h0001, 16'h0000);
        chk({15'h0, lnk}, 16'h0001, "link up");
        pe.set_links(1'b0, 1'b0);
        @(negedge clk_sys_i);
        chk({15'h0, hold}, 16'h0001, "link loss");
        wait_burst();
        pe.set_links(1'b1, 1'b1);
        repeat (2) @(negedge clk_sys_i);
        chk({15'h0, done}, 16'h0000, "two links");
        chk_rd(5'h06, 16'h0010, 16'h0010);
        pe.set_links(1'b1, 1'b0);
        @(negedge clk_sys_i);
        chk({13'h0, done, spd100, fdx}, 16'h0004, "pd 10");
        chk_rd(5'h05, 16'hFFFF, 16'h0021);
        pe.set_links(1'b0, 1'b0);
        wait_burst();
        $display("parallel done");
    endtask : test_parallel

    task automatic test_forced();
        boot(1'b0, 1'b0, 1'b0);
        wr(5'h00, 16'h2100);
        chk({13'h0, hold, spd100, fdx}, 16'h0003, "ctrl forced");
        chk_rd(5'h10, 16'h0006, 16'h0004);
        wr(5'h00, 16'h0000);
        chk({13'h0, hold, spd100, fdx}, 16'h0000, "ctrl 10 half");
        wr(5'h00, 16'h1000);
        chk({15'h0, hold}, 16'h0001, "enable");
        wait_burst();
        $display("forced done");
    endtask : test_forced

    task automatic test_done();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        arst_n_i   = 1'b0;
        req        = '0;
        {neg_s, spd_s, dup_s} = 3'h7;
        fail_count = 0;
        checked    = 0;
        test_straps();
        test_priority();
        test_parallel();
        test_forced();
        test_done();
    end
    // Whole run is about 500 cycles
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fail_count++;
        $display("BAD t=%0t watchdog", $time);
        test_done();
    end
endmodule : ean_autoneg_test
